// ===== src/spimsp_top.sv
// Overview of operation
// - Full duplex eight-bit transfers, serial rate up to 20 Mbps.
// - Master-in line is input as master, driven output as slave.
// - Master-out line is driven as master, input as slave.
// - Serial words are eight bits, most significant bit first.
// - One byte completes after exactly eight serial clock periods.
// - Serial clock driven as master, accepted as input as slave.
// - Master clock rate equals system clock over two times (divider plus one).
// - Master clock idle level and sample phase follow control settings.
// - Slave settings match external master; its clock at most 10 Mbps.
// - Launch on one edge, sample on the opposite edge.
// - Slave transfer starts on select low, shifts bytes until select high.
// - Master pulls select low at transfer start, high at completion.
// - Divider register is eight bits, read/write, resets to zero.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`include "spimsp_params.svh"
module spimsp_top #(
    parameter int FIFO_DEPTH = `SPIMSP_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sclkIn,
    output logic sclkOut,
    output logic sclkOe,
    input wire logic mosiIn,
    output logic mosiOut,
    output logic mosiOe,
    input wire logic misoIn,
    output logic misoOut,
    output logic misoOe,
    input wire logic selectInN,
    output logic selectOutN,
    output logic selectOe
);
    import spimsp_pkg::*;

    localparam int LW = $clog2(FIFO_DEPTH + 1);

    typedef struct packed {
        logic awHave;
        logic [7:0] awAddr;
        logic wHave;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] ctrl;
        logic [7:0] div;
        logic rxOvf;
        spimsp_phase_t phase;
        logic [7:0] divCnt;
        logic [2:0] bitCnt;
        logic [7:0] txSh;
        logic [7:0] rxSh;
        logic sclk;
        logic csN;
        logic mosi;
        logic miso;
        logic sclkOe;
        logic mosiOe;
        logic misoOe;
        logic csOe;
        logic [2:0] pinsD;
        logic rxPush;
        logic [7:0] rxWord;
    } spimsp_state_t;

    spimsp_state_t st;
    spimsp_state_t next_st;

    logic txValid, txReady, txPop, txPush, rxValid, rxReady, rxPop, rxPushReady;
    logic [7:0] txData, rxData;
    logic [LW-1:0] txLevel, rxLevel;
    logic [2:0] pins;
    logic [2:0] pinIdle;
    logic enable, master, cpol, cpha;
    logic sSclk, sMosi, sSel;
    logic edgeRise, edgeFall, lead, trail, selFall, selRise;
    logic [31:0] statusWord;
    logic wrFire;
    logic [31:0] wMask;

    assign enable = st.ctrl[`SPIMSP_CTRL_EN];
    assign master = st.ctrl[`SPIMSP_CTRL_MASTER];
    assign cpol = st.ctrl[`SPIMSP_CTRL_CPOL];
    assign cpha = st.ctrl[`SPIMSP_CTRL_CPHA];

    // Pins from the far side: clock, data in, select (idle select is high)
    assign pinIdle = 3'b100;
    spimsp_sync #(.WIDTH(3)) u_sync (
        .clk(clk),
        .rst(rst),
        .async({selectInN, mosiIn, sclkIn} ^ pinIdle),
        .resetVal(pinIdle),
        .level(pins)
    );
    assign sSclk = pins[0];
    assign sMosi = pins[1];
    assign sSel = pins[2];

    // Slave edges relative to the idle level; select low starts a transfer
    assign edgeRise = (sSclk != st.pinsD[0]) && (sSclk != cpol);
    assign edgeFall = (sSclk != st.pinsD[0]) && (sSclk == cpol);
    // Lead launches and trail samples; phase one launches on the leading edge
    assign lead = cpha ? edgeRise : edgeFall;
    assign trail = cpha ? edgeFall : edgeRise;
    assign selFall = !sSel && st.pinsD[2];
    assign selRise = sSel && !st.pinsD[2];

    // Transmit bytes from software and received bytes to software
    spimsp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_txfifo (
        .clk(clk),
        .rst(rst),
        .inValid(txPush),
        .inReady(txReady),
        .inData(st.wData[7:0]),
        .outValid(txValid),
        .outReady(txPop),
        .outData(txData),
        .level(txLevel)
    );
    spimsp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rxfifo (
        .clk(clk),
        .rst(rst),
        .inValid(st.rxPush),
        .inReady(rxPushReady),
        .inData(st.rxWord),
        .outValid(rxValid),
        .outReady(rxPop),
        .outData(rxData),
        .level(rxLevel)
    );

    assign statusWord = {23'h000000, !txReady, st.rxOvf, 3'(rxLevel), 3'(txLevel),
        st.phase != SPIMSP_IDLE};
    assign wrFire = st.awHave && st.wHave && !st.bvalid;
    assign wMask = {{8{st.wStrb[3]}}, {8{st.wStrb[2]}}, {8{st.wStrb[1]}}, {8{st.wStrb[0]}}};
    assign txPush = wrFire && (st.awAddr == `SPIMSP_TX_OFS) && st.wStrb[0] && txReady;
    assign rxPop = s_axi_arvalid && st.arready && (s_axi_araddr == `SPIMSP_RX_OFS) && rxValid;
    assign rxReady = rxPushReady;

    always_comb begin
        next_st = st;
        txPop = 1'b0;
        next_st.rxPush = 1'b0;
        next_st.pinsD = pins;

        // Write channel: address and data caught separately, answered together
        if (s_axi_awvalid && !st.awHave) begin
            next_st.awHave = 1'b1;
            next_st.awAddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st.wHave) begin
            next_st.wHave = 1'b1;
            next_st.wData = s_axi_wdata;
            next_st.wStrb = s_axi_wstrb;
        end
        if (wrFire) begin
            next_st.awHave = 1'b0;
            next_st.wHave = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = `SPIMSP_RESP_OKAY;
            unique case (st.awAddr)
                `SPIMSP_CTRL_OFS: begin
                    next_st.ctrl = (st.ctrl & ~wMask[7:0]) | (st.wData[7:0] & wMask[7:0]);
                end
                `SPIMSP_DIV_OFS: begin
                    next_st.div = (st.div & ~wMask[7:0]) | (st.wData[7:0] & wMask[7:0]);
                end
                `SPIMSP_TX_OFS: begin
                    // A full transmit queue drops the byte and reports an error
                    if (!txReady) begin
                        next_st.bresp = `SPIMSP_RESP_SLVERR;
                    end
                end
                `SPIMSP_STATUS_OFS, `SPIMSP_RX_OFS: begin
                    next_st.bresp = `SPIMSP_RESP_SLVERR;
                end
                default: begin
                    next_st.bresp = `SPIMSP_RESP_SLVERR;
                end
            endcase
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end

        // Read channel: one read at a time, data from a register
        if (s_axi_arvalid && st.arready) begin
            next_st.arready = 1'b0;
            next_st.rvalid = 1'b1;
            next_st.rresp = `SPIMSP_RESP_OKAY;
            unique case (s_axi_araddr)
                `SPIMSP_STATUS_OFS: begin
                    next_st.rdata = statusWord;
                    next_st.rxOvf = 1'b0;
                end
                `SPIMSP_RX_OFS: next_st.rdata = {24'h000000, rxValid ? rxData : 8'h00};
                `SPIMSP_TX_OFS: next_st.rdata = 32'h00000000;
                `SPIMSP_DIV_OFS: next_st.rdata = {24'h000000, st.div};
                `SPIMSP_CTRL_OFS: next_st.rdata = {24'h000000, st.ctrl};
                default: begin
                    next_st.rdata = 32'h00000000;
                    next_st.rresp = `SPIMSP_RESP_SLVERR;
                end
            endcase
        end
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        // Ready whenever no answer is pending; a held request must not stall
        next_st.arready = !next_st.rvalid;

        // Pin directions follow the mode
        next_st.sclkOe = enable && master;
        next_st.mosiOe = enable && master;
        next_st.csOe = enable && master;
        next_st.misoOe = enable && !master && !sSel;

        unique case (st.phase)
            SPIMSP_IDLE: begin
                next_st.sclk = cpol;
                next_st.csN = 1'b1;
                next_st.divCnt = 8'h00;
                next_st.bitCnt = 3'h0;
                if (enable && master && txValid) begin
                    // Master starts one byte; select goes low first
                    txPop = 1'b1;
                    next_st.txSh = txData;
                    next_st.csN = 1'b0;
                    next_st.mosi = txData[7];
                    next_st.phase = SPIMSP_LEAD;
                end else if (enable && !master && selFall) begin
                    next_st.txSh = txValid ? txData : 8'h00;
                    txPop = txValid;
                    next_st.miso = txValid ? txData[7] : 1'b0;
                    next_st.phase = SPIMSP_SHIFT;
                end
            end
            SPIMSP_LEAD, SPIMSP_SHIFT: begin
                if (master) begin
                    // Each half period lasts div+1 system clocks
                    if (st.divCnt == st.div) begin
                        next_st.divCnt = 8'h00;
                        next_st.sclk = !st.sclk;
                        if ((st.sclk == cpol) != cpha) begin
                            // Sampling edge
                            next_st.rxSh = {st.rxSh[6:0], misoIn};
                            if (cpha) begin
                                next_st.bitCnt = st.bitCnt + 3'h1;
                                if (st.bitCnt == 3'h7) begin
                                    next_st.rxPush = 1'b1;
                                    next_st.rxWord = {st.rxSh[6:0], misoIn};
                                    next_st.phase = SPIMSP_TAIL;
                                end
                            end
                        end else begin
                            // Launch edge
                            if (!cpha) begin
                                next_st.bitCnt = st.bitCnt + 3'h1;
                                if (st.bitCnt == 3'h7) begin
                                    next_st.sclk = cpol;
                                    next_st.rxPush = 1'b1;
                                    next_st.rxWord = st.rxSh;
                                    next_st.phase = SPIMSP_TAIL;
                                end else begin
                                    next_st.txSh = {st.txSh[6:0], 1'b0};
                                    next_st.mosi = st.txSh[6];
                                end
                            end else begin
                                next_st.mosi = st.txSh[7];
                                next_st.txSh = {st.txSh[6:0], 1'b0};
                            end
                        end
                    end else begin
                        next_st.divCnt = st.divCnt + 8'h01;
                    end
                end else begin
                    // Slave: external clock, select bounds the transfer
                    if (selRise || !enable) begin
                        next_st.phase = SPIMSP_IDLE;
                    end else if (trail) begin
                        next_st.rxSh = {st.rxSh[6:0], sMosi};
                        next_st.bitCnt = st.bitCnt + 3'h1;
                        if (st.bitCnt == 3'h7) begin
                            next_st.rxPush = 1'b1;
                            next_st.rxWord = {st.rxSh[6:0], sMosi};
                            if (txValid) begin
                                txPop = 1'b1;
                                next_st.txSh = txData;
                                if (cpha) begin
                                    next_st.miso = st.miso;
                                end else begin
                                    next_st.miso = txData[7];
                                end
                            end else begin
                                next_st.txSh = 8'h00;
                            end
                        end
                    end else if (lead) begin
                        if (cpha) begin
                            next_st.miso = st.txSh[7];
                            next_st.txSh = {st.txSh[6:0], 1'b0};
                        end else if (st.bitCnt != 3'h0) begin
                            next_st.miso = st.txSh[6];
                            next_st.txSh = {st.txSh[6:0], 1'b0};
                        end
                    end
                end
            end
            SPIMSP_TAIL: begin
                // Hold select low for one half period, then release
                next_st.sclk = cpol;
                if (st.divCnt == st.div) begin
                    next_st.csN = 1'b1;
                    next_st.phase = SPIMSP_IDLE;
                end else begin
                    next_st.divCnt = st.divCnt + 8'h01;
                end
            end
        endcase

        // Full receive queue loses the new byte and flags it
        if (st.rxPush && !rxReady) begin
            next_st.rxOvf = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
            st.ctrl <= `SPIMSP_CTRL_RESET;
            st.div <= `SPIMSP_DIV_RESET;
            st.csN <= 1'b1;
            st.phase <= SPIMSP_IDLE;
            st.pinsD <= 3'b100;
        end else begin
            st <= next_st;
        end
    end

    // Every output straight from the state register
    assign s_axi_awready = !st.awHave;
    assign s_axi_wready = !st.wHave;
    assign s_axi_bresp = st.bresp;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_arready = st.arready;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
    assign s_axi_rvalid = st.rvalid;
    assign sclkOut = st.sclk;
    assign sclkOe = st.sclkOe;
    assign mosiOut = st.mosi;
    assign mosiOe = st.mosiOe;
    assign misoOut = st.miso;
    assign misoOe = st.misoOe;
    assign selectOutN = st.csN;
    assign selectOe = st.csOe;
endmodule

// ===== src/spimsp_params.svh
`ifndef SPIMSP_PARAMS_SVH
`define SPIMSP_PARAMS_SVH

// Register byte offsets
`define SPIMSP_STATUS_OFS 8'h00
`define SPIMSP_RX_OFS 8'h04
`define SPIMSP_TX_OFS 8'h08
`define SPIMSP_DIV_OFS 8'h0c
`define SPIMSP_CTRL_OFS 8'h10

// Control fields
`define SPIMSP_CTRL_EN 0
`define SPIMSP_CTRL_MASTER 1
`define SPIMSP_CTRL_CPOL 2
`define SPIMSP_CTRL_CPHA 3
`define SPIMSP_CTRL_RESET 8'h00
`define SPIMSP_DIV_RESET 8'h00

// Status fields
`define SPIMSP_STA_BUSY 0
`define SPIMSP_STA_TXLVL 1
`define SPIMSP_STA_RXLVL 4
`define SPIMSP_STA_RXOVF 7
`define SPIMSP_STA_TXFULL 8

// AXI responses
`define SPIMSP_RESP_OKAY 2'h0
`define SPIMSP_RESP_SLVERR 2'h2

// Byte width and FIFO depth
`define SPIMSP_BITS 8
`define SPIMSP_FIFO_DEPTH 4

`endif

// ===== src/spimsp_pkg.sv
package spimsp_pkg;
    typedef enum logic [1:0] {
        SPIMSP_IDLE,
        SPIMSP_LEAD,
        SPIMSP_SHIFT,
        SPIMSP_TAIL
    } spimsp_phase_t;
endpackage

// ===== src/spimsp_fifo.sv
`timescale 1ns/10ps
module spimsp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [CW-1:0] cnt;
        logic [WIDTH-1:0] dout;
        logic dvalid;
    } spimsp_fifo_st_t;

    spimsp_fifo_st_t st;
    spimsp_fifo_st_t next_st;
    logic push;
    logic pop;
    logic load;

    // Output word stays registered; one entry is held in the output stage
    always_comb begin
        next_st = st;
        push = inValid && inReady;
        pop = outValid && outReady;
        load = (st.cnt != '0) && (!st.dvalid || pop);
        if (push) begin
            next_st.mem[st.wp] = inData;
            next_st.wp = (st.wp == AW'(DEPTH - 1)) ? '0 : st.wp + 1'b1;
        end
        if (load) begin
            next_st.dout = st.mem[st.rp];
            next_st.rp = (st.rp == AW'(DEPTH - 1)) ? '0 : st.rp + 1'b1;
            next_st.dvalid = 1'b1;
        end else if (pop) begin
            next_st.dvalid = 1'b0;
        end
        next_st.cnt = st.cnt + CW'(push) - CW'(load);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Output stage counts as part of the depth, so full is honest
    assign inReady = (CW'(st.cnt) + CW'(st.dvalid)) < CW'(DEPTH);
    assign outValid = st.dvalid;
    assign outData = st.dout;
    assign level = st.cnt + CW'(st.dvalid);
endmodule

// ===== src/spimsp_sync.sv
`timescale 1ns/10ps
module spimsp_sync #(
    parameter int WIDTH = 3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] async,
    input wire logic [WIDTH-1:0] resetVal,
    output logic [WIDTH-1:0] level
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] lvl;
    } spimsp_sync_st_t;

    spimsp_sync_st_t st;
    spimsp_sync_st_t next_st;

    // Three stages; the level moves only when stage two and three agree
    always_comb begin
        next_st = st;
        next_st.s1 = async;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.lvl[i] = st.s3[i];
            end
        end
    end

    // Reset clears every stage to zero; idle levels come from the resetVal port at the output
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign level = st.lvl ^ resetVal;
endmodule

// ===== dv/spimsp_checker.sv
`timescale 1ns/10ps
module spimsp_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sclkOut,
    input wire logic sclkOe,
    input wire logic mosiOe,
    input wire logic misoOe,
    input wire logic selectInN,
    input wire logic selectOutN,
    input wire logic selectOe
);
    logic [5:0] edges;
    logic prevSclk;

    // Count clock toggles inside a frame; idle polarity changes are ignored
    always_ff @(posedge clk) begin
        prevSclk <= sclkOut;
        if (rst || selectOutN) begin
            edges <= 6'h00;
        end else if (sclkOut != prevSclk) begin
            edges <= edges + 6'h01;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_EIGHT_PERIODS: assert property ($rose(selectOutN) |-> edges == 6'h10)
        else $error("frame without sixteen clock edges");
    AST_SEL_DRIVEN: assert property (!selectOutN |-> selectOe && sclkOe && mosiOe)
        else $error("select low while master pins undriven");
    AST_MISO_SLAVE: assert property (misoOe |-> !sclkOe && !mosiOe && !selectOe)
        else $error("data out driven outside slave mode");
    AST_MISO_START: assert property ($rose(misoOe) |-> !$past(selectInN, 2))
        else $error("slave output without select");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    AST_B_AFTER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    AST_R_AFTER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
endmodule

// ===== dv/spimsp_slave_model.sv
`timescale 1ns/10ps
module spimsp_slave_model (
    input wire logic sclk,
    input wire logic selN,
    input wire logic mosi,
    input wire logic cpol,
    input wire logic cpha,
    input wire logic [7:0] reply,
    output logic miso,
    output logic [7:0] got
);
    logic [7:0] tx;

    initial miso = 1'b0;

    // Load reply; leading-edge sampling needs the first bit up front
    always @(negedge selN) begin
        tx = reply;
        if (!cpha) begin
            miso = tx[7];
            tx = tx << 1;
        end
    end

    // Released line shows the inverse, so a stale bit cannot pass
    always @(posedge selN) miso = ~miso;

    // Sample on one edge, launch on the other
    always @(sclk) begin
        if (!selN && (sclk ^ cpol ^ cpha)) begin
            got = {got[6:0], mosi};
        end else if (!selN) begin
            miso = tx[7];
            tx = tx << 1;
        end
    end
endmodule

// ===== dv/tb_top.sv
`timescale 1ns/10ps
`include "spimsp_params.svh"
module tb_top;
    localparam logic [7:0] DIV = `SPIMSP_DIV_OFS;
    localparam logic [7:0] CTL = `SPIMSP_CTRL_OFS;
    localparam logic [7:0] TXO = `SPIMSP_TX_OFS;
    localparam logic [7:0] RXO = `SPIMSP_RX_OFS;
    localparam logic [1:0] OK = `SPIMSP_RESP_OKAY;
    localparam logic [1:0] ER = `SPIMSP_RESP_SLVERR;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic sclkOut, sclkOe, mosiOut, mosiOe, misoOut, misoOe, selectOutN, selectOe;
    logic mosiIn = 1'b0, selectInN = 1'b1, tbSclk = 1'b0, pol = 1'b0, pha = 1'b0;
    logic [7:0] reply = 8'h00, got;
    wire sclkIn;
    wire misoIn;
    int fails = 0, num_checks = 0;
    // Row inputs: divider, sent byte, peer reply; mode is the row index
    logic [7:0] dv[4] = '{8'h00, 8'h01, 8'h02, 8'h03};
    logic [7:0] tx[4] = '{8'ha5, 8'h3c, 8'h81, 8'h5a};
    logic [7:0] rep[4] = '{8'h69, 8'hf0, 8'h0f, 8'hc3};

    // Clock pin level from whoever drives it
    assign sclkIn = sclkOe ? sclkOut : tbSclk;
    always #2.5 clk = ~clk;

    spimsp_top DUT (.*);
    spimsp_slave_model PEER (.sclk(sclkOut), .selN(selectOutN), .mosi(mosiOut), .cpol(pol),
        .cpha(pha), .reply(reply), .miso(misoIn), .got(got));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One write; address and data released as each is taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk(32'(s_axi_bresp), 32'(e));
    endtask

    task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        chk(s_axi_rdata, ed);
        chk(32'(s_axi_rresp), 32'(e));
    endtask

    // Edge count until a pin reaches a level; the watchdog bounds it
    task automatic waitv(ref logic s, input logic v, inout int n);
        while (s !== v) begin
            @(posedge clk);
            n++;
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        int n;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(32'({selectOutN, selectOe, sclkOe, mosiOe, misoOe}), 32'h10);
        axr(DIV, 32'h0, OK);
        axr(`SPIMSP_STATUS_OFS, 32'h0, OK);
        axw(DIV, 32'h1a5, OK);
        axr(DIV, 32'ha5, OK);
        axr(8'h40, 32'h0, ER);
        axw(`SPIMSP_STATUS_OFS, 32'h1, ER);
        $display("register test done");
        // Every clock mode with its own divider
        for (int i = 0; i < 4; i++) begin
            pol <= i[1];
            pha <= i[0];
            reply <= rep[i];
            axw(DIV, 32'(dv[i]), OK);
            axw(CTL, {28'h0, i[0], i[1], 2'h3}, OK);
            repeat (2) @(posedge clk);
            chk(32'({selectOutN, sclkOut}), 32'({1'b1, pol}));
            axw(TXO, 32'(tx[i]), OK);
            n = 0;
            waitv(selectOutN, 1'b0, n);
            waitv(sclkOut, ~pol, n);
            n = 0;
            waitv(sclkOut, pol, n);
            waitv(sclkOut, ~pol, n);
            chk(32'(n), 32'(2 * (dv[i] + 1)));
            waitv(selectOutN, 1'b1, n);
            chk(32'(got), 32'(tx[i]));
            chk(32'(sclkOut), 32'(pol));
            axr(RXO, 32'(rep[i]), OK);
            $display("row %0d done", i);
        end
        // Two queued bytes give two separate select frames
        axw(TXO, 32'h81, OK);
        axw(TXO, 32'h7e, OK);
        n = 0;
        waitv(selectOutN, 1'b0, n);
        waitv(selectOutN, 1'b1, n);
        waitv(selectOutN, 1'b0, n);
        waitv(selectOutN, 1'b1, n);
        chk(32'(got), 32'h7e);
        axr(RXO, 32'(rep[3]), OK);
        axr(RXO, 32'(rep[3]), OK);
        $display("back to back test done");
        // Slave, mode 0, 20-cycle clock period runs at the 10 Mbps limit
        axw(CTL, 32'h1, OK);
        selectInN <= 1'b0;
        repeat (10) @(posedge clk);
        for (int k = 7; k >= 0; k--) begin
            mosiIn <= k[0] ^ k[1];
            repeat (10) @(posedge clk);
            tbSclk <= 1'b1;
            repeat (10) @(posedge clk);
            tbSclk <= 1'b0;
        end
        chk(32'({misoOe, mosiOe, sclkOe, selectOe, misoOut}), 32'h10);
        repeat (10) @(posedge clk);
        selectInN <= 1'b1;
        mosiIn <= ~mosiIn;
        repeat (10) @(posedge clk);
        axr(RXO, 32'h66, OK);
        $display("slave test done");
        final_report();
    end

    // Hang guard, well beyond the expected run
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        final_report();
    end
endmodule

bind spimsp_top spimsp_checker CHK (.*);
